// >>> hdl/ulm_defs.vh
// constants shared by the serial port logic: register offsets, field positions,
// reset values and encodings; assumes an 8-bit word-aligned register address
`ifndef ULM_DEFS_VH
`define ULM_DEFS_VH

// register byte offsets
`define ULM_OFF_LINMR 8'h00
`define ULM_OFF_LINIR 8'h04
`define ULM_OFF_CTRL 8'h08
`define ULM_OFF_STATUS 8'h0c
`define ULM_OFF_RHR 8'h10
`define ULM_OFF_MANCFG 8'h14
`define ULM_OFF_MANTX 8'h18
`define ULM_OFF_LINTD 8'h1c
`define ULM_OFF_LINRD 8'h20

`define ULM_LINMR_RESET 17'h00000
`define ULM_LINMR_W 17

// lin_mode_config fields
`define ULM_NODE_RESPONSE_ACTION 1:0
`define ULM_ID_PARITY_DISABLE_B 2
`define ULM_CHECKSUM_DISABLE_B 3
`define ULM_CHKKIND_B 4
`define ULM_LENSEL_B 5
`define ULM_DLC 15:8
`define ULM_NODE_RESPONSE_ACTION_PUBLISH 2'h0
`define ULM_NODE_RESPONSE_ACTION_SUBSCRIBE 2'h1
`define ULM_NODE_RESPONSE_ACTION_IGNORE 2'h2

// control register fields
`define ULM_MODE 3:0
`define ULM_WRITE_PROTECT_ENABLE_B 8
`define ULM_MODE_LIN_MASTER 4'ha
`define ULM_MODE_LIN_SLAVE 4'hb

// status register bits
`define ULM_ST_MAN_RDY 0
`define ULM_ST_MAN_ERR 1
`define ULM_ST_PAR_ERR 2
`define ULM_ST_CHK_ERR 3
`define ULM_ST_LIN_DONE 4
`define ULM_ST_LIN_RDY 5
`define ULM_ST_TXH_FULL 6
`define ULM_ST_ENC_BUSY 7
`define ULM_ST_LIN_BUSY 8

// manchester config and frame layout
`define ULM_SFD_ONE_B 0
`define ULM_PRE_LEN 11:8
`define ULM_TX_CMD_B 8
`define ULM_RHR_KIND_B 8
`define ULM_SYNC_CMD 6'h38
`define ULM_SYNC_DATA 6'h07
`define ULM_PRE_PATTERN 30'h2aaaaaaa
`define ULM_HALVES_ONE 6'h11
`define ULM_HALVES_SYNC 6'h17
`define ULM_HALVES_HDR 5'h07

// identifier length coding when the length comes from the identifier
`define ULM_LEN_2 9'h002
`define ULM_LEN_4 9'h004
`define ULM_LEN_8 9'h008

`endif

// >>> hdl/ulm_man_enc.v
// manchester encoder: preamble of zero bits, start half, optional sync, 8 data bits
// assumes start is a one-cycle pulse from the register block on the same clock
`timescale 1ns/10ps
`include "ulm_defs.vh"

module ulm_man_enc #(
  parameter HALF_CYCLES = 8
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire start,
  input wire [7:0] data,
  input wire cmd_sync,
  input wire single_bit,
  input wire [3:0] pre_len,
  output wire busy,
  output reg txd_q
);

  reg [63:0] sh_q;
  reg [5:0] left_q;
  reg [15:0] tim_q;
  wire [15:0] dh;
  wire [63:0] pre_al;
  wire [63:0] core_al;
  wire [63:0] mask;
  wire [5:0] pre2;

  // bit one is low then high, bit zero high then low
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_half
      assign dh[15-2*i] = ~data[i];
      assign dh[14-2*i] = data[i];
    end
  endgenerate

  assign pre2 = {1'b0, pre_len, 1'b0};
  assign mask = ~({64{1'b1}} >> pre2);
  assign pre_al = {`ULM_PRE_PATTERN, 34'h0} & mask;
  assign core_al = single_bit ? {1'b1, dh, 47'h0} :
                   {1'b1, (cmd_sync ? `ULM_SYNC_CMD : `ULM_SYNC_DATA), dh, 41'h0};
  assign busy = (left_q != 6'h0);

  ////////////////////////////////////////////////////////////////////////////
  // serial emit
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_q <= 64'h0;
      left_q <= 6'h0;
      tim_q <= 16'h0;
      txd_q <= 1'b0;
    end else if (ce) begin
      if (!busy) begin
        txd_q <= 1'b0;
        if (start) begin
          sh_q <= pre_al | (core_al >> pre2);
          left_q <= pre2 + (single_bit ? `ULM_HALVES_ONE : `ULM_HALVES_SYNC);
          tim_q <= 16'h0;
        end
      end else if (tim_q == 16'h0) begin
        txd_q <= sh_q[63];
        sh_q <= {sh_q[62:0], 1'b0};
        tim_q <= HALF_CYCLES[15:0] - 16'h1;
        left_q <= left_q - 6'h1;
      end else begin
        tim_q <= tim_q - 16'h1;
      end
    end
  end

endmodule

// >>> hdl/ulm_ctrl.v
// serial port logic: manchester decoder and encoder control, lin node control
// register port on the same clock; man_rxd is asynchronous; lin byte streams
// come from and go to the character engine on this clock
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "ulm_defs.vh"

module ulm_ctrl #(
  parameter HALF_CYCLES = 8
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  input wire man_rxd,
  output wire man_txd,
  input wire lin_rx_valid,
  input wire [7:0] lin_rx_byte,
  output reg lin_tx_valid_q,
  output reg [7:0] lin_tx_byte_q,
  input wire lin_tx_ready
);

  localparam ST_IDLE = 6'h01;
  localparam ST_SEND_ID = 6'h02;
  localparam ST_TX_DATA = 6'h04;
  localparam ST_TX_CHK = 6'h08;
  localparam ST_RX_DATA = 6'h10;
  localparam ST_RX_CHK = 6'h20;

  reg [`ULM_LINMR_W-1:0] linmr_q;
  reg [7:0] id_q;
  reg [8:0] ctrl_q;
  reg [11:0] mancfg_q;
  reg [8:0] rhr_q;
  reg [7:0] lin_rd_q;
  reg [7:0] txh_q;
  reg txh_full_q;
  reg man_rdy_q, man_err_q, par_err_q, chk_err_q, lin_done_q, lin_rdy_q;
  reg [5:0] st_q, st_d;
  reg [8:0] cnt_q;
  reg [7:0] sum_q;
  reg rx_s1_q, rx_s2_q, rx_s3_q, rx_lvl_q;
  reg dec_act_q;
  reg [15:0] dec_tim_q;
  reg [5:0] dec_n_q;
  reg [22:0] dec_sh_q;
  reg dec_one_q;

  wire enc_busy;
  wire [31:0] status;
  wire wr_linmr, wr_linir, wr_status, wr_mantx, wr_lintd;
  wire rd_rhr, rd_linrd;
  wire lin_en, is_master;
  wire slot_free;
  wire [7:0] ext_id;
  wire [1:0] node_response_action;
  wire id_parity_disable, checksum_disable;
  wire [7:0] pbyte_sw;
  wire [7:0] rx_pid;
  wire rx_par_bad;
  wire [7:0] dec_data;
  wire [7:0] dec_ok;
  reg last_tx, last_rx;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [7:0] pid;
    input [5:0] id;
    begin
      pid = {~(id[1] ^ id[3] ^ id[4] ^ id[5]), id[0] ^ id[1] ^ id[2] ^ id[4], id};
    end
  endfunction

  // carry wraps back into the low byte
  function [7:0] csum_add;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      csum_add = s[7:0] + {7'h0, s[8]};
    end
  endfunction

  function [8:0] resp_len;
    input [7:0] id;
    input lensel;
    input [7:0] response_length_count;
    begin
      if (lensel) begin
        case (id[6:5])
          2'h3: resp_len = `ULM_LEN_8;
          2'h2: resp_len = `ULM_LEN_4;
          default: resp_len = `ULM_LEN_2;
        endcase
      end else begin
        resp_len = {1'b0, response_length_count} + 9'h001;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  assign lin_en = (ctrl_q[`ULM_MODE] == `ULM_MODE_LIN_MASTER) || (ctrl_q[`ULM_MODE] == `ULM_MODE_LIN_SLAVE);
  assign is_master = ctrl_q[`ULM_MODE] == `ULM_MODE_LIN_MASTER;
  assign node_response_action = linmr_q[`ULM_NODE_RESPONSE_ACTION];
  assign id_parity_disable = linmr_q[`ULM_ID_PARITY_DISABLE_B];
  assign checksum_disable = linmr_q[`ULM_CHECKSUM_DISABLE_B];

  assign wr_linmr = reg_wr && reg_addr == `ULM_OFF_LINMR && !ctrl_q[`ULM_WRITE_PROTECT_ENABLE_B];
  assign wr_linir = reg_wr && reg_addr == `ULM_OFF_LINIR;
  assign wr_status = reg_wr && reg_addr == `ULM_OFF_STATUS;
  assign wr_mantx = reg_wr && reg_addr == `ULM_OFF_MANTX && !enc_busy;
  assign wr_lintd = reg_wr && reg_addr == `ULM_OFF_LINTD && !txh_full_q;
  assign rd_rhr = reg_rd && reg_addr == `ULM_OFF_RHR;
  assign rd_linrd = reg_rd && reg_addr == `ULM_OFF_LINRD;

  assign status = {23'h0, !st_q[0], enc_busy, txh_full_q, lin_rdy_q, lin_done_q,
                   chk_err_q, par_err_q, man_err_q, man_rdy_q};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= 32'h0;
    end else if (ce) begin
      reg_rdata_q <= 32'h0;
      if (reg_rd) begin
        case (reg_addr)
          `ULM_OFF_LINMR: reg_rdata_q <= {15'h0, linmr_q};
          `ULM_OFF_LINIR: reg_rdata_q <= {24'h0, id_q};
          `ULM_OFF_CTRL: reg_rdata_q <= {23'h0, ctrl_q};
          `ULM_OFF_STATUS: reg_rdata_q <= status;
          `ULM_OFF_RHR: reg_rdata_q <= {23'h0, rhr_q};
          `ULM_OFF_MANCFG: reg_rdata_q <= {20'h0, mancfg_q};
          `ULM_OFF_LINRD: reg_rdata_q <= {24'h0, lin_rd_q};
          default: reg_rdata_q <= 32'h0;
        endcase
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      linmr_q <= `ULM_LINMR_RESET;
      ctrl_q <= 9'h0;
      mancfg_q <= 12'h0;
    end else if (ce) begin
      if (wr_linmr)
        linmr_q <= reg_wdata[`ULM_LINMR_W-1:0];
      if (reg_wr && reg_addr == `ULM_OFF_CTRL)
        ctrl_q <= reg_wdata[8:0];
      if (reg_wr && reg_addr == `ULM_OFF_MANCFG)
        mancfg_q <= reg_wdata[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // manchester transmit

  ulm_man_enc #(
    .HALF_CYCLES(HALF_CYCLES)
  ) u_enc (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .start(wr_mantx),
    .data(reg_wdata[7:0]),
    .cmd_sync(reg_wdata[`ULM_TX_CMD_B]),
    .single_bit(mancfg_q[`ULM_SFD_ONE_B]),
    .pre_len(mancfg_q[`ULM_PRE_LEN]),
    .busy(enc_busy),
    .txd_q(man_txd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // manchester receive

  // a level change counts once the second and third stages agree
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1_q <= 1'b0;
      rx_s2_q <= 1'b0;
      rx_s3_q <= 1'b0;
      rx_lvl_q <= 1'b0;
    end else if (ce) begin
      rx_s1_q <= man_rxd;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
      if (rx_s2_q == rx_s3_q)
        rx_lvl_q <= rx_s3_q;
    end
  end

  // bit value is the second half; equal halves mean a coding violation
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_dec
      assign dec_data[gi] = dec_sh_q[14-2*gi];
      assign dec_ok[gi] = dec_sh_q[15-2*gi] ^ dec_sh_q[14-2*gi];
    end
  endgenerate

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dec_act_q <= 1'b0;
      dec_tim_q <= 16'h0;
      dec_n_q <= 6'h0;
      dec_sh_q <= 23'h0;
      dec_one_q <= 1'b0;
    end else if (ce) begin
      if (!dec_act_q) begin
        // frame opens on a rising transition
        if (rx_lvl_q == 1'b0 && rx_s2_q == rx_s3_q && rx_s3_q) begin
          dec_act_q <= 1'b1;
          dec_tim_q <= HALF_CYCLES[16:1];
          dec_n_q <= 6'h0;
          dec_one_q <= mancfg_q[`ULM_SFD_ONE_B];
        end
      end else if (dec_tim_q != 16'h0) begin
        dec_tim_q <= dec_tim_q - 16'h1;
      end else begin
        dec_sh_q <= {dec_sh_q[21:0], rx_lvl_q};
        dec_n_q <= dec_n_q + 6'h1;
        dec_tim_q <= HALF_CYCLES[15:0] - 16'h1;
        // either sync kind passes; anything else re-arms
        // sync halves sit in the low six bits once the start half and six more are in
        if (!dec_one_q && dec_n_q == {1'b0, `ULM_HALVES_HDR} &&
            dec_sh_q[5:0] != `ULM_SYNC_CMD && dec_sh_q[5:0] != `ULM_SYNC_DATA)
          dec_act_q <= 1'b0;
        if (dec_n_q == (dec_one_q ? `ULM_HALVES_ONE : `ULM_HALVES_SYNC))
          dec_act_q <= 1'b0;
      end
    end
  end

  // the frame completes one sample after the last half is taken
  wire dec_fin = dec_act_q && dec_tim_q == 16'h0 &&
                 dec_n_q == (dec_one_q ? `ULM_HALVES_ONE : `ULM_HALVES_SYNC);

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rhr_q <= 9'h0;
    end else if (ce) begin
      // character and sync kind stored together
      if (dec_fin && dec_ok == 8'hff)
        rhr_q <= {!dec_one_q && dec_sh_q[21:16] == `ULM_SYNC_CMD, dec_data};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lin node control

  assign slot_free = !lin_tx_valid_q || lin_tx_ready;
  assign ext_id = {2'h0, reg_wdata[5:0]};
  assign pbyte_sw = id_parity_disable ? reg_wdata[7:0] : pid(reg_wdata[5:0]);
  assign rx_pid = pid(lin_rx_byte[5:0]);
  assign rx_par_bad = !id_parity_disable && rx_pid[7:6] != lin_rx_byte[7:6];

  always @* begin
    st_d = st_q;
    last_tx = cnt_q == 9'h001;
    last_rx = cnt_q == 9'h001;
    case (st_q)
      ST_IDLE: begin
        if (lin_en && is_master && wr_linir)
          st_d = ST_SEND_ID;
        else if (lin_en && !is_master && lin_rx_valid)
          // slave picks its path from node action
          st_d = node_response_action == `ULM_NODE_RESPONSE_ACTION_PUBLISH ? ST_TX_DATA :
                 node_response_action == `ULM_NODE_RESPONSE_ACTION_SUBSCRIBE ? ST_RX_DATA : ST_IDLE;
      end
      ST_SEND_ID: begin
        // master picks its path from node action
        if (slot_free)
          st_d = node_response_action == `ULM_NODE_RESPONSE_ACTION_PUBLISH ? ST_TX_DATA :
                 node_response_action == `ULM_NODE_RESPONSE_ACTION_SUBSCRIBE ? ST_RX_DATA : ST_IDLE;
      end
      ST_TX_DATA: begin
        if (slot_free && txh_full_q && last_tx)
          st_d = (!checksum_disable && is_master) ? ST_TX_CHK : ST_IDLE;
      end
      ST_TX_CHK: begin
        if (slot_free)
          st_d = ST_IDLE;
      end
      ST_RX_DATA: begin
        if (lin_rx_valid && last_rx)
          st_d = (!checksum_disable && !is_master) ? ST_RX_CHK : ST_IDLE;
      end
      ST_RX_CHK: begin
        if (lin_rx_valid)
          st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    // leaving lin mode abandons the frame
    if (!lin_en)
      st_d = ST_IDLE;
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      id_q <= 8'h0;
      cnt_q <= 9'h0;
      sum_q <= 8'h0;
      lin_tx_valid_q <= 1'b0;
      lin_tx_byte_q <= 8'h0;
      lin_rd_q <= 8'h0;
      txh_q <= 8'h0;
    end else if (ce) begin
      st_q <= st_d;
      if (lin_tx_ready)
        lin_tx_valid_q <= 1'b0;
      if (wr_lintd)
        txh_q <= reg_wdata[7:0];
      if (wr_linir && st_q == ST_IDLE)
        id_q <= (lin_en && is_master) ? pbyte_sw : ext_id;
      if (st_q == ST_IDLE && lin_en && !is_master && lin_rx_valid) begin
        id_q <= lin_rx_byte;
        cnt_q <= resp_len(lin_rx_byte, linmr_q[`ULM_LENSEL_B], linmr_q[`ULM_DLC]);
        sum_q <= linmr_q[`ULM_CHKKIND_B] ? 8'h0 : lin_rx_byte;
      end
      if (st_q == ST_SEND_ID && slot_free) begin
        lin_tx_valid_q <= 1'b1;
        lin_tx_byte_q <= id_q;
        cnt_q <= resp_len(id_q, linmr_q[`ULM_LENSEL_B], linmr_q[`ULM_DLC]);
        sum_q <= linmr_q[`ULM_CHKKIND_B] ? 8'h0 : id_q;
      end
      if (st_q == ST_TX_DATA && slot_free && txh_full_q) begin
        lin_tx_valid_q <= 1'b1;
        lin_tx_byte_q <= txh_q;
        sum_q <= csum_add(sum_q, txh_q);
        cnt_q <= cnt_q - 9'h001;
      end
      if (st_q == ST_TX_CHK && slot_free) begin
        lin_tx_valid_q <= 1'b1;
        lin_tx_byte_q <= ~sum_q;
      end
      if (st_q == ST_RX_DATA && lin_rx_valid) begin
        lin_rd_q <= lin_rx_byte;
        sum_q <= csum_add(sum_q, lin_rx_byte);
        cnt_q <= cnt_q - 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: a hardware set beats a clear in the same cycle

  wire set_man_rdy = dec_fin && dec_ok == 8'hff;
  wire set_man_err = dec_fin && dec_ok != 8'hff;
  wire set_par = st_q == ST_IDLE && lin_en && !is_master && lin_rx_valid && rx_par_bad;
  wire set_chk = st_q == ST_RX_CHK && lin_rx_valid && lin_rx_byte != ~sum_q;
  wire set_done = st_q != ST_IDLE && st_d == ST_IDLE && lin_en;
  wire set_lrdy = st_q == ST_RX_DATA && lin_rx_valid;
  wire take_txh = st_q == ST_TX_DATA && slot_free && txh_full_q;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      man_rdy_q <= 1'b0;
      man_err_q <= 1'b0;
      par_err_q <= 1'b0;
      chk_err_q <= 1'b0;
      lin_done_q <= 1'b0;
      lin_rdy_q <= 1'b0;
      txh_full_q <= 1'b0;
    end else if (ce) begin
      man_rdy_q <= set_man_rdy || (man_rdy_q && !rd_rhr);
      man_err_q <= set_man_err || (man_err_q && !(wr_status && reg_wdata[`ULM_ST_MAN_ERR]));
      par_err_q <= set_par || (par_err_q && !(wr_status && reg_wdata[`ULM_ST_PAR_ERR]));
      chk_err_q <= set_chk || (chk_err_q && !(wr_status && reg_wdata[`ULM_ST_CHK_ERR]));
      lin_done_q <= set_done || (lin_done_q && !(wr_status && reg_wdata[`ULM_ST_LIN_DONE]));
      lin_rdy_q <= set_lrdy || (lin_rdy_q && !rd_linrd);
      txh_full_q <= wr_lintd || (txh_full_q && !take_txh);
    end
  end

endmodule

// >>> tb/ulm_ctrl_props.sv
// assertions on the serial port top: register port, lin byte stream, reset
// assumes one clock domain and the register offsets of ulm_defs.vh
`timescale 1ns/10ps
`include "ulm_defs.vh"
module ulm_ctrl_props #(
  parameter HALF_CYCLES = 8
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata_q,
  input wire man_rxd,
  input wire man_txd,
  input wire lin_rx_valid,
  input wire [7:0] lin_rx_byte,
  input wire lin_tx_valid_q,
  input wire [7:0] lin_tx_byte_q,
  input wire lin_tx_ready
);
  reg [3:0] mode_q;
  reg write_protect_enable_q;
  reg [16:0] linmr_q;
  reg [7:0] idexp_q;
  wire wr_ok = ce && reg_wr;
  wire lin_on = (mode_q == 4'ha) || (mode_q == 4'hb);
  wire [7:0] w = reg_wdata[7:0];
  wire [7:0] w_par = {~(w[1] ^ w[3] ^ w[4] ^ w[5]), w[0] ^ w[1] ^ w[2] ^ w[4], w[5:0]};
  ////////////////////////////////////////////////////////////////////////////////
  // shadow of mode, protection and the lin mode register
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q <= 4'h0;
      write_protect_enable_q <= 1'b0;
      linmr_q <= 17'h00000;
      idexp_q <= 8'h00;
    end else if (wr_ok) begin
      if (reg_addr == `ULM_OFF_CTRL) begin
        mode_q <= reg_wdata[3:0];
        write_protect_enable_q <= reg_wdata[8];
      end
      if (reg_addr == `ULM_OFF_LINMR && !write_protect_enable_q)
        linmr_q <= reg_wdata[16:0];
      if (reg_addr == `ULM_OFF_LINIR)
        idexp_q <= linmr_q[2] ? w : w_par;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata_q == 32'h0)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (ce && reg_rd && reg_addr > 8'h20 |=> reg_rdata_q == 32'h0)
    else $error("unmapped read not zero");
  linmr_readback_a: assert property (ce && reg_rd && reg_addr == `ULM_OFF_LINMR |=>
    reg_rdata_q == {15'h0, linmr_q}) else $error("lin mode register content wrong");
  txvalid_hold_a: assert property (lin_tx_valid_q && !lin_tx_ready && !(reg_wr && reg_addr == `ULM_OFF_CTRL)
    |=> lin_tx_valid_q && $stable(lin_tx_byte_q)) else $error("tx byte dropped before ready");
  nonlin_quiet_a: assert property (!lin_on && !lin_tx_valid_q |=> !lin_tx_valid_q)
    else $error("lin traffic outside lin modes");
  id_parity_a: assert property (wr_ok && reg_addr == `ULM_OFF_LINIR && mode_q == 4'ha && !lin_tx_valid_q
    ##2 $rose(lin_tx_valid_q) |-> lin_tx_byte_q == idexp_q) else $error("identifier byte wrong");
  reset_quiet_a: assert property ($rose(resetn) |-> !lin_tx_valid_q && !man_txd && reg_rdata_q == 32'h0)
    else $error("outputs not idle after reset");
  ce_freeze_a: assert property (!ce |=> $stable(reg_rdata_q) && $stable(lin_tx_valid_q) && $stable(man_txd))
    else $error("outputs moved with clock enable low");
  cover property (lin_tx_valid_q && !lin_tx_ready);
  cover property (wr_ok && reg_addr == `ULM_OFF_LINMR && write_protect_enable_q);
  cover property ($rose(lin_tx_valid_q) && mode_q == 4'ha);
endmodule
bind ulm_ctrl ulm_ctrl_props #(.HALF_CYCLES(HALF_CYCLES)) i_ulm_ctrl_props (.clk(clk), .resetn(resetn),
  .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q), .man_rxd(man_rxd), .man_txd(man_txd), .lin_rx_valid(lin_rx_valid),
  .lin_rx_byte(lin_rx_byte), .lin_tx_valid_q(lin_tx_valid_q), .lin_tx_byte_q(lin_tx_byte_q),
  .lin_tx_ready(lin_tx_ready));

// >>> tb/ulm_far_node.sv
// far side model: lin node taking tx bytes and sending rx bytes, rf receiver
// driving manchester frames; assumes the bench calls its tasks one at a time
`timescale 1ns/10ps
module ulm_far_node #(
  parameter HALF = 4
) (
  input wire clk,
  input wire slow,
  input wire lin_tx_valid_q,
  input wire [7:0] lin_tx_byte_q,
  output reg lin_tx_ready,
  output reg lin_rx_valid,
  output reg [7:0] lin_rx_byte,
  output reg man_rxd
);
  reg [7:0] got [0:63];
  integer cnt;
  initial begin
    lin_tx_ready = 1'b1;
    lin_rx_valid = 1'b0;
    lin_rx_byte = 8'h00;
    man_rxd = 1'b0;
    cnt = 0;
  end
  // slow mode refuses every other cycle to stall the sender
  always @(posedge clk) begin
    if (lin_tx_valid_q && lin_tx_ready) begin
      got[cnt % 64] <= lin_tx_byte_q;
      cnt <= cnt + 1;
    end
    lin_tx_ready <= slow ? ~lin_tx_ready : 1'b1;
  end
  // released data shows the inverse so a stale byte is never mistaken
  task send_rx(input [7:0] b);
    begin
      @(posedge clk);
      lin_rx_byte <= b;
      lin_rx_valid <= 1'b1;
      @(posedge clk);
      lin_rx_valid <= 1'b0;
      lin_rx_byte <= ~b;
    end
  endtask
  task send_man(input cmd, input [7:0] d);
    reg [22:0] h;
    integer i;
    begin
      h[0] = 1'b1;
      h[6:1] = cmd ? 6'b000111 : 6'b111000;
      for (i = 0; i < 8; i = i + 1) begin
        h[7 + 2 * i] = ~d[i];
        h[8 + 2 * i] = d[i];
      end
      for (i = 0; i < 23; i = i + 1) begin
        @(posedge clk);
        man_rxd <= h[i];
        repeat (HALF - 1) @(posedge clk);
      end
      @(posedge clk);
      man_rxd <= 1'b0;
    end
  endtask
endmodule

// >>> tb/ulm_ctrl_tb_top.sv
// bench for the serial port logic: register tasks, lin master frames and slave headers,
// manchester receive and transmit; assumes the far side model ulm_far_node
`timescale 1ns/10ps
module ulm_ctrl_tb_top;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg ce = 1'b1;
  reg slow = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [31:0] reg_rdata_q;
  wire man_rxd, man_txd, lin_rx_valid, lin_tx_valid_q, lin_tx_ready;
  wire [7:0] lin_rx_byte, lin_tx_byte_q;
  integer miscompares = 0;
  integer tests_run = 0;
  integer k;
  reg [31:0] v;
  always #2.5 clk = ~clk;
  ulm_ctrl #(.HALF_CYCLES(4)) i_ulm_ctrl (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .man_rxd(man_rxd),
    .man_txd(man_txd), .lin_rx_valid(lin_rx_valid), .lin_rx_byte(lin_rx_byte),
    .lin_tx_valid_q(lin_tx_valid_q), .lin_tx_byte_q(lin_tx_byte_q), .lin_tx_ready(lin_tx_ready));
  ulm_far_node #(.HALF(4)) i_ulm_far_node (.clk(clk), .slow(slow), .lin_tx_valid_q(lin_tx_valid_q),
    .lin_tx_byte_q(lin_tx_byte_q), .lin_tx_ready(lin_tx_ready), .lin_rx_valid(lin_rx_valid),
    .lin_rx_byte(lin_rx_byte), .man_rxd(man_rxd));
  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
    end
  endtask
  task rdm(input [7:0] a, input [31:0] m, input [31:0] e);
    begin
      rd(a, v);
      chk(v & m, e);
    end
  endtask
  // a limit that runs out ends the run
  task poll(input integer b, input x);
    begin
      v = 32'h0;
      v[b] = ~x;
      for (k = 0; k < 400 && v[b] !== x; k = k + 1) rd(8'h0c, v);
      if (v[b] !== x) begin
        miscompares = miscompares + 1;
        final_report;
      end
    end
  endtask
  task waitcnt(input integer t);
    begin
      for (k = 0; k < 400 && i_ulm_far_node.cnt != t; k = k + 1) @(posedge clk);
      if (i_ulm_far_node.cnt != t) begin
        miscompares = miscompares + 1;
        final_report;
      end
    end
  endtask
  function [7:0] par(input [7:0] i);
    par = {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i[5:0]};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // one master frame: id, then n response bytes sent or received, then checksum
  task frame(input [31:0] cfg, input [7:0] id, input integer n);
    integer i, base, tot;
    reg [8:0] s;
    reg [7:0] idb, d;
    begin
      wr(8'h08, 32'ha);
      wr(8'h00, cfg);
      base = i_ulm_far_node.cnt;
      idb = cfg[2] ? id : par(id);
      s = cfg[4] ? 9'h0 : {1'b0, idb};
      wr(8'h04, {24'h0, id});
      waitcnt(base + 1);
      for (i = 0; i < n; i = i + 1) begin
        d = (cfg[0] ? 8'h5a : 8'ha0) + i[7:0];
        if (cfg[0]) begin
          i_ulm_far_node.send_rx(d);
          poll(5, 1'b1);
          rdm(8'h20, 32'hff, {24'h0, d});
        end else begin
          poll(6, 1'b0);
          wr(8'h1c, {24'h0, d});
        end
        s = s + d;
        s = s[7:0] + s[8];
      end
      if (cfg[0]) i_ulm_far_node.send_rx(~s[7:0]);
      tot = cfg[1:0] == 2'h0 ? n + 2 - cfg[3] : 1;
      waitcnt(base + tot);
      poll(4, 1'b1);
      chk(i_ulm_far_node.cnt, base + tot);
      chk({24'h0, i_ulm_far_node.got[base]}, {24'h0, idb});
      for (i = 0; i < tot - 1; i = i + 1)
        chk({24'h0, i_ulm_far_node.got[base + 1 + i]}, i < n ? 32'ha0 + i : {24'h0, ~s[7:0]});
      wr(8'h0c, 32'h10);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rdm(8'h00, 32'hffffffff, 32'h0);
    rdm(8'h08, 32'hffffffff, 32'h0);
    wr(8'h40, 32'hffffffff);
    rdm(8'h40, 32'hffffffff, 32'h0);
    wr(8'h00, 32'h10534);
    rdm(8'h00, 32'hffffffff, 32'h10534);
    wr(8'h08, 32'h100);
    wr(8'h00, 32'h0);
    rdm(8'h00, 32'hffffffff, 32'h10534);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h12);
    repeat (20) @(posedge clk);
    chk(i_ulm_far_node.cnt, 0);
    frame(32'h0, 8'h05, 1);
    frame(32'h110, 8'h23, 2);
    frame(32'h4, 8'h3f, 1);
    slow <= 1'b1;
    frame(32'h8, 8'h11, 1);
    frame(32'h20, 8'h41, 4);
    frame(32'h20, 8'h62, 8);
    frame(32'h20, 8'h12, 2);
    slow <= 1'b0;
    frame(32'h1, 8'h07, 1);
    frame(32'h2, 8'h09, 0);
    wr(8'h08, 32'hb);
    wr(8'h00, 32'h2);
    i_ulm_far_node.send_rx(par(8'h05) ^ 8'h40);
    poll(2, 1'b1);
    rdm(8'h04, 32'hff, {24'h0, par(8'h05) ^ 8'h40});
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h4);
    wr(8'h08, 32'hb);
    wr(8'h00, 32'h6);
    i_ulm_far_node.send_rx(8'h85);
    rdm(8'h04, 32'hff, 32'h85);
    rdm(8'h0c, 32'h4, 32'h0);
    wr(8'h08, 32'h0);
    i_ulm_far_node.send_man(1'b1, 8'h96);
    poll(0, 1'b1);
    rdm(8'h10, 32'h1ff, 32'h196);
    i_ulm_far_node.send_man(1'b0, 8'h3c);
    poll(0, 1'b1);
    rdm(8'h10, 32'h1ff, 32'h03c);
    wr(8'h14, 32'h200);
    wr(8'h18, 32'h1a5);
    rdm(8'h0c, 32'h80, 32'h80);
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    for (k = 0; k < 300 && man_txd !== 1'b1; k = k + 1) @(posedge clk);
    chk({31'h0, man_txd}, 32'h1);
    poll(7, 1'b0);
    final_report;
  end
endmodule
